// ### hdl/pll_cfg_regs.vh
// register offsets, field positions, reset values for the divider and sleep bank
`ifndef PLL_CFG_REGS_VH
`define PLL_CFG_REGS_VH
// ----------------------------------------
// register indices and address width
// ----------------------------------------
`define IDX_CLOCK_DIVIDER_CONFIG 8'h19
`define IDX_VCO_BAND_SLEEP 8'h1a
`define IDX_REF_FUSE_CONTROL 8'h1b
`define ADDR_W 10
// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_CLOCK_DIVIDER_CONFIG 16'h0440
`define RST_VCO_BAND_SLEEP 16'h0020
`define RST_REF_FUSE_CONTROL 16'h0000
// ----------------------------------------
// field positions
// ----------------------------------------
`define F_M_HI 15
`define F_M_LO 8
`define F_N_HI 7
`define F_N_LO 4
`define F_ITUNE_HI 3
`define F_ITUNE_LO 2
`define F_VCO_HI 15
`define F_VCO_LO 10
`define B_BIAS_SLEEP 7
`define B_TSENSE_SLEEP 6
`define B_PLL_SLEEP 5
`define B_CLKRECV_SLEEP 4
`define B_CHAN_A 3
`define B_CHAN_B 2
`define B_CHAN_C 1
`define B_CHAN_D 0
`define B_EXTREF 15
`define B_FUSE_SLEEP 11
// ----------------------------------------
// bus answers
// ----------------------------------------
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ### hdl/cfg_word.v
// one 16-bit configuration word with reset value and write strobe
`timescale 1ns/1ps
module cfg_word #(
  parameter [15:0] RESET_VALUE = 16'h0000
) (
  // clock and reset
  input wire core_clk,
  input wire reset,
  input wire clk_en,
  // write side
  input wire wr_en,
  input wire [1:0] wr_strb,
  input wire [15:0] wr_data,
  // stored value
  output reg [15:0] value_r
);
  // storage: loads reset value, takes written bytes, holds otherwise
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      value_r <= RESET_VALUE;
    end else if (clk_en && wr_en) begin
      if (wr_strb[0]) begin
        value_r[7:0] <= wr_data[7:0];
      end
      if (wr_strb[1]) begin
        value_r[15:8] <= wr_data[15:8];
      end
    end
  end
endmodule

// ### hdl/pll_divider_decode.v
// turns the m and n divider codes into divide values
`timescale 1ns/1ps
module pll_divider_decode (
  // divider codes
  input wire [7:0] m_code,
  input wire [3:0] n_code,
  // decoded values
  output wire [7:0] m_divide,
  output wire m_valid,
  output wire [4:0] n_divide
);
  // m: direct low seven bits or twice them
  assign m_divide = m_code[7] ? {m_code[6:0], 1'b0} : {1'b0, m_code[6:0]};
  // direct mode needs 4..127, doubled mode needs 8..254
  assign m_valid = m_code[7] ? (m_code[6:0] >= 7'h04) : (m_code[6:0] >= 7'h04);
  // n: code plus one, every code legal
  assign n_divide = {1'b0, n_code} + 5'h01;
endmodule

// ### hdl/pll_divider_and_sleep_regs.v
// axi4-lite register bank for divider, vco band, sleep and reference controls
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "pll_cfg_regs.vh"
module pll_divider_and_sleep_regs (
  // clock, reset, enable
  input wire core_clk,
  input wire reset,
  input wire clk_en,
  // axi4-lite write address
  input wire [`ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [`ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // divider controls
  output reg [7:0] pll_m_divide,
  output reg pll_m_valid,
  output reg [4:0] pll_n_divide,
  output reg [1:0] vco_bias_trim,
  // vco band and sleep controls
  output reg [5:0] vco_coarse_band,
  output reg bias_amp_sleep,
  output reg temp_sensor_off,
  output reg pll_sleep,
  output reg clock_receiver_sleep,
  output reg sync_reference_input_sleep,
  output reg chan_a_power_down,
  output reg chan_b_power_down,
  output reg chan_c_power_down,
  output reg chan_d_power_down,
  // reference and fuse controls
  output reg external_ref_select,
  output reg trim_fuse_sleep
);
  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // word index from a byte address; returns 0..2 for a mapped word, 3 otherwise
  function [1:0] word_sel;
    input [`ADDR_W-1:0] addr;
    begin
      if (addr[1:0] != 2'b00) begin
        word_sel = 2'd3;
      end else if (addr[`ADDR_W-1:2] == `IDX_CLOCK_DIVIDER_CONFIG) begin
        word_sel = 2'd0;
      end else if (addr[`ADDR_W-1:2] == `IDX_VCO_BAND_SLEEP) begin
        word_sel = 2'd1;
      end else if (addr[`ADDR_W-1:2] == `IDX_REF_FUSE_CONTROL) begin
        word_sel = 2'd2;
      end else begin
        word_sel = 2'd3;
      end
    end
  endfunction

  // ----------------------------------------
  // write channel
  // ----------------------------------------
  reg [`ADDR_W-1:0] aw_addr_r; // latched write address
  reg aw_held_r; // write address taken, waiting for data
  reg [31:0] w_data_r; // latched write data
  reg [3:0] w_strb_r; // latched strobes
  reg w_held_r; // write data taken, waiting for address
  wire do_write; // both halves present and no response pending
  wire [1:0] wsel; // selected word for the write
  wire [2:0] word_wr; // write enable per word

  // accept each half while it is not yet held and no response waits
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;
  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wsel = word_sel(aw_addr_r);
  assign word_wr[0] = do_write && (wsel == 2'd0);
  assign word_wr[1] = do_write && (wsel == 2'd1);
  assign word_wr[2] = do_write && (wsel == 2'd2);

  // capture address and data in either order, then answer
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      aw_addr_r <= {`ADDR_W{1'b0}};
      aw_held_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      w_held_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (clk_en) begin
      // address half
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_r <= s_axi_awaddr;
        aw_held_r <= 1'b1;
      end
      // data half
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        w_held_r <= 1'b1;
      end
      // both present: perform and respond
      if (do_write) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wsel == 2'd3) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // configuration words
  // ----------------------------------------
  wire [15:0] div_word; // clock_divider_config
  wire [15:0] sleep_word; // vco_band_and_sleep_control
  wire [15:0] ref_word; // reference_and_fuse_control

  // divider word, reset 0440
  cfg_word #(
    .RESET_VALUE(`RST_CLOCK_DIVIDER_CONFIG)
  ) u_div_word (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .wr_en(word_wr[0]),
    .wr_strb(w_strb_r[1:0]),
    .wr_data(w_data_r[15:0]),
    .value_r(div_word)
  );

  // band and sleep word, reset 0020
  cfg_word #(
    .RESET_VALUE(`RST_VCO_BAND_SLEEP)
  ) u_sleep_word (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .wr_en(word_wr[1]),
    .wr_strb(w_strb_r[1:0]),
    .wr_data(w_data_r[15:0]),
    .value_r(sleep_word)
  );

  // reference and fuse word, reset 0000
  cfg_word #(
    .RESET_VALUE(`RST_REF_FUSE_CONTROL)
  ) u_ref_word (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .wr_en(word_wr[2]),
    .wr_strb(w_strb_r[1:0]),
    .wr_data(w_data_r[15:0]),
    .value_r(ref_word)
  );

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  wire [1:0] rsel; // selected word for the read
  reg [15:0] rd_word; // word chosen by the read address

  // one read outstanding: take a new address only when no data waits
  assign s_axi_arready = !s_axi_rvalid;
  assign rsel = word_sel(s_axi_araddr);

  // read mux; unmapped reads return zero
  always @* begin
    rd_word = 16'h0000;
    case (rsel)
      2'd0: begin
        rd_word = div_word;
      end
      2'd1: begin
        rd_word = sleep_word;
      end
      2'd2: begin
        rd_word = ref_word;
      end
      default: begin
        rd_word = 16'h0000;
      end
    endcase
  end

  // register read data; upper half reads zero
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {16'h0000, rd_word};
        s_axi_rresp <= (rsel == 2'd3) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // divider decode
  // ----------------------------------------
  wire [7:0] m_div_c; // decoded m divide
  wire m_valid_c; // m code legal
  wire [4:0] n_div_c; // decoded n divide

  // combinational decode of the m and n codes
  pll_divider_decode u_decode (
    .m_code(div_word[`F_M_HI:`F_M_LO]),
    .n_code(div_word[`F_N_HI:`F_N_LO]),
    .m_divide(m_div_c),
    .m_valid(m_valid_c),
    .n_divide(n_div_c)
  );

  // ----------------------------------------
  // control outputs
  // ----------------------------------------
  // register the analog controls so they change cleanly one edge after a write
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pll_m_divide <= 8'h04;
      pll_m_valid <= 1'b1;
      pll_n_divide <= 5'h05;
      vco_bias_trim <= 2'b00;
      vco_coarse_band <= 6'h00;
      bias_amp_sleep <= 1'b0;
      temp_sensor_off <= 1'b0;
      pll_sleep <= 1'b1;
      clock_receiver_sleep <= 1'b0;
      sync_reference_input_sleep <= 1'b0;
      chan_a_power_down <= 1'b0;
      chan_b_power_down <= 1'b0;
      chan_c_power_down <= 1'b0;
      chan_d_power_down <= 1'b0;
      external_ref_select <= 1'b0;
      trim_fuse_sleep <= 1'b0;
    end else if (clk_en) begin
      // divider values
      pll_m_divide <= m_div_c;
      pll_m_valid <= m_valid_c;
      pll_n_divide <= n_div_c;
      // bias trim passed as stored; software chooses 01
      vco_bias_trim <= div_word[`F_ITUNE_HI:`F_ITUNE_LO];
      // coarse band
      vco_coarse_band <= sleep_word[`F_VCO_HI:`F_VCO_LO];
      // sleep controls
      bias_amp_sleep <= sleep_word[`B_BIAS_SLEEP];
      temp_sensor_off <= sleep_word[`B_TSENSE_SLEEP];
      pll_sleep <= sleep_word[`B_PLL_SLEEP];
      clock_receiver_sleep <= sleep_word[`B_CLKRECV_SLEEP];
      sync_reference_input_sleep <= sleep_word[`B_CLKRECV_SLEEP];
      chan_a_power_down <= sleep_word[`B_CHAN_A];
      chan_b_power_down <= sleep_word[`B_CHAN_B];
      chan_c_power_down <= sleep_word[`B_CHAN_C];
      chan_d_power_down <= sleep_word[`B_CHAN_D];
      // reference and fuses
      external_ref_select <= ref_word[`B_EXTREF];
      trim_fuse_sleep <= ref_word[`B_FUSE_SLEEP];
    end
  end
endmodule

// ### tb/pll_regs_checker_sva.sv
// assertion checker for the divider and sleep register bank
`timescale 1ns/1ps
module pll_regs_checker (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // control outputs
  input wire logic [7:0] pll_m_divide,
  input wire logic pll_m_valid,
  input wire logic [4:0] pll_n_divide,
  input wire logic pll_sleep,
  input wire logic clock_receiver_sleep,
  input wire logic sync_reference_input_sleep
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // both write halves taken together, then an enabled edge
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clk_en ##1 clk_en;
  endsequence
  // read address taken
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready && clk_en;
  endsequence
  chk_recv_pair_tie: assert property (clock_receiver_sleep == sync_reference_input_sleep)
    else $error("receiver sleep outputs differ");
  chk_n_range: assert property (pll_n_divide >= 5'h01 && pll_n_divide <= 5'h10)
    else $error("n divide out of range");
  chk_m_odd_low: assert property (pll_m_divide[0] |-> pll_m_divide < 8'h80)
    else $error("odd m divide above 127");
  chk_m_valid_floor: assert property (pll_m_valid ? pll_m_divide >= 8'h04 : pll_m_divide < 8'h08)
    else $error("m valid flag wrong");
  chk_reset_values: assert property ($past(reset) |-> pll_sleep && pll_n_divide == 5'h05 && pll_m_divide == 8'h04)
    else $error("controls not at reset values");
  chk_write_answer: assert property (both_taken |=> s_axi_bvalid)
    else $error("write response late");
  chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_read_answer: assert property (ar_taken |=> s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000)
    else $error("read data late or wide");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule
bind pll_divider_and_sleep_regs pll_regs_checker u_chk (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pll_m_divide(pll_m_divide), .pll_m_valid(pll_m_valid),
  .pll_n_divide(pll_n_divide), .pll_sleep(pll_sleep), .clock_receiver_sleep(clock_receiver_sleep),
  .sync_reference_input_sleep(sync_reference_input_sleep));

// ### tb/pll_divider_and_sleep_regs_bench.sv
// self-checking bench for the divider and sleep register bank
`timescale 1ns/1ps
`include "pll_cfg_regs.vh"
module pll_divider_and_sleep_regs_bench;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1; // freeze is not exercised
  logic [9:0] s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] pll_m_divide;
  logic [4:0] pll_n_divide;
  logic [1:0] vco_bias_trim;
  logic [5:0] vco_coarse_band;
  logic pll_m_valid, bias_amp_sleep, temp_sensor_off, pll_sleep, clock_receiver_sleep, sync_reference_input_sleep;
  logic chan_a_power_down, chan_b_power_down, chan_c_power_down, chan_d_power_down;
  logic external_ref_select, trim_fuse_sleep;
  integer errors = 0, cmp_count = 0, i;
  logic [15:0] w;
  logic [7:0] mc;
  localparam [9:0] A_DIV = {`IDX_CLOCK_DIVIDER_CONFIG, 2'b00};
  localparam [9:0] A_SLP = {`IDX_VCO_BAND_SLEEP, 2'b00};
  localparam [9:0] A_REF = {`IDX_REF_FUSE_CONTROL, 2'b00};

  // free-running 100 MHz clock
  always #5 core_clk = ~core_clk;

  pll_divider_and_sleep_regs DUT (.core_clk, .reset, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pll_m_divide, .pll_m_valid, .pll_n_divide, .vco_bias_trim, .vco_coarse_band, .bias_amp_sleep,
    .temp_sensor_off, .pll_sleep, .clock_receiver_sleep, .sync_reference_input_sleep, .chan_a_power_down,
    .chan_b_power_down, .chan_c_power_down, .chan_d_power_down, .external_ref_select, .trim_fuse_sleep);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // verdict and end of run
  task complete_run;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
        $display("Regression OK");
      end else begin
        $display("Regression broken");
      end
      $finish;
    end
  endtask
  // one comparison
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // write one word, halves released when taken, response checked
  task wr(input logic [9:0] a, input logic [15:0] d, input logic [3:0] s, input logic [1:0] r);
    integer n;
    logic ta, tw, b;
    logic [1:0] rs;
    begin
      ta = 1'b0;
      tw = 1'b0;
      b = 1'b0;
      n = 0;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {16'h0000, d};
      s_axi_wstrb <= s;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!b && n < 50) begin
        @(negedge core_clk);
        ta = ta | s_axi_awready;
        tw = tw | s_axi_wready;
        b = s_axi_bvalid;
        rs = s_axi_bresp;
        @(posedge core_clk);
        if (ta) s_axi_awvalid <= 1'b0;
        if (tw) s_axi_wvalid <= 1'b0;
        n = n + 1;
      end
      s_axi_bready <= 1'b0;
      chk({31'h0, b}, 32'h1);
      if (!b) complete_run;
      chk({30'h0, rs}, {30'h0, r});
    end
  endtask
  // read one word and compare data and response
  task rd(input logic [9:0] a, input logic [31:0] d, input logic [1:0] r);
    integer n;
    logic ta, b;
    logic [31:0] got;
    logic [1:0] rs;
    begin
      ta = 1'b0;
      b = 1'b0;
      n = 0;
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!b && n < 50) begin
        @(negedge core_clk);
        ta = ta | s_axi_arready;
        b = s_axi_rvalid;
        got = s_axi_rdata;
        rs = s_axi_rresp;
        @(posedge core_clk);
        if (ta) s_axi_arvalid <= 1'b0;
        n = n + 1;
      end
      s_axi_rready <= 1'b0;
      chk({31'h0, b}, 32'h1);
      if (!b) complete_run;
      chk(got, d);
      chk({30'h0, rs}, {30'h0, r});
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    rd(A_DIV, 32'h00000440, 2'b00);
    rd(A_SLP, 32'h00000020, 2'b00);
    rd(A_REF, 32'h00000000, 2'b00);
    @(negedge core_clk);
    chk({pll_m_divide, pll_m_valid, pll_n_divide, pll_sleep}, {8'h04, 1'b1, 5'h05, 1'b1});
    // every n code, m codes in both halves
    for (i = 0; i < 16; i = i + 1) begin
      mc = 8'(i * 17);
      w = {mc, i[3:0], 4'h4};
      wr(A_DIV, w, 4'h3, 2'b00);
      @(negedge core_clk);
      chk({pll_m_divide, pll_m_valid, pll_n_divide, vco_bias_trim},
        {mc[7] ? {mc[6:0], 1'b0} : {1'b0, mc[6:0]}, mc[6:0] >= 7'h04, 5'(i + 1), 2'b01});
      rd(A_DIV, {16'h0000, w}, 2'b00);
    end
    // walking one through the sleep word
    for (i = 0; i < 16; i = i + 1) begin
      w = 16'h0001 << i;
      wr(A_SLP, w, 4'h3, 2'b00);
      @(negedge core_clk);
      chk({vco_coarse_band, bias_amp_sleep, temp_sensor_off, pll_sleep, clock_receiver_sleep,
        sync_reference_input_sleep, chan_a_power_down, chan_b_power_down, chan_c_power_down, chan_d_power_down},
        {w[15:10], w[7:4], w[4:0]});
      rd(A_SLP, {16'h0000, w}, 2'b00);
    end
    wr(A_SLP, 16'hffff, 4'h1, 2'b00);
    rd(A_SLP, 32'h000080ff, 2'b00);
    // reference select and fuse sleep
    for (i = 0; i < 3; i = i + 1) begin
      w = {i[0], 3'h0, i[1], 11'h000};
      wr(A_REF, w, 4'h3, 2'b00);
      @(negedge core_clk);
      chk({external_ref_select, trim_fuse_sleep}, {w[15], w[11]});
      rd(A_REF, {16'h0000, w}, 2'b00);
    end
    // unmapped and unaligned places
    wr(10'h070, 16'h1234, 4'h3, 2'b10);
    rd(10'h070, 32'h00000000, 2'b10);
    wr(10'h065, 16'h0000, 4'h3, 2'b10);
    rd(A_DIV, 32'h0000fff4, 2'b00);
    rd(10'h066, 32'h00000000, 2'b10);
    complete_run;
  end
endmodule
